// ===== bench/i2c_master_command_engine_bench.sv
// Self-checking bench for the I2C master command engine
`include "i2c_master_command_engine_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_master_command_engine_bench import i2c_master_command_engine_pkg::*;;
  localparam logic [6:0] SADDR = 7'h5a;
  localparam int         TIMEOUT = 100000;
  logic        mclk = 1'b0;
  logic        resetn;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        irq;
  logic        hs_mode;
  logic        slv_oe;
  logic        slv_scl;
  logic        oth_oe;
  logic        nack_data;
  logic        stretch;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic [7:0]  addr_byte;
  logic [31:0] seed;
  logic [31:0] r;
  int          n_errors;
  int          tests_run;
  int          cyc = 0;
  logic [31:0] refused [4] = '{32'hf, 32'h1, 32'h5, 32'h4};
  wire         scl_w = ~(scl_oe | slv_scl);
  wire         sda_w = ~(sda_oe | slv_oe | oth_oe);

  i2c_master_command_engine i2c_master_command_engine_i (
    .I_MCLK(mclk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb), .I_RD(rd_stb),
    .O_RDATA(rdata), .I_SCL(scl_w), .O_SCL(), .O_SCL_OE(scl_oe), .I_SDA(sda_w), .O_SDA(),
    .O_SDA_OE(sda_oe), .O_IRQ(irq), .O_HS_MODE(hs_mode));

  i2c_slave_model #(.ADDR(SADDR)) i2c_slave_model_i (
    .scl(scl_w), .sda(sda_w), .nack_data(nack_data), .stretch(stretch), .tx_byte(tx_byte),
    .sda_oe(slv_oe), .scl_oe(slv_scl), .rx_byte(rx_byte), .addr_byte(addr_byte));

  always #12.5 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction

  function automatic logic [31:0] status_exp(input logic an, input logic dn, input logic al);
    return {19'h0, al, dn, an, an | dn | al, 1'b0, 8'h00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      #1;
      i++;
    end while (irq !== 1'b1 && i < 20000);
    chk({31'h0, irq}, 32'h1);
  endtask

  task automatic xfer(input logic [31:0] c, input logic [7:0] d);
    wr(`BUF_OFFSET, {24'h0, d});
    wr(`MCS_OFFSET, c);
    if (c[0]) begin
      rd(`MCS_OFFSET, r);
      chk({31'h0, r[`MCS_BUSY_BIT]}, 32'h1);
    end
    wait_irq();
  endtask

  task automatic tx(input logic [31:0] c, input logic [7:0] d);
    xfer(c, d);
    chk({24'h0, rx_byte}, {24'h0, d});
  endtask

  task automatic rx(input logic [31:0] c, input logic [7:0] d);
    tx_byte = d;
    xfer(c, 8'h00);
    rd(`BUF_OFFSET, r);
    chk(r, {24'h0, d});
  endtask

  task automatic idle_chk();
    repeat (400) @(posedge mclk);
    #1;
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
  endtask

  // Refused commands must leave the pins as they were and raise no interrupt
  task automatic quiet(input logic [31:0] c);
    logic [2:0] seen;
    logic [1:0] pins;
    pins = {scl_oe, sda_oe};
    seen = 3'h0;
    wr(`MCS_OFFSET, c);
    repeat (500) begin
      @(posedge mclk);
      #1;
      seen = seen | {{scl_oe, sda_oe} ^ pins, irq};
    end
    chk({29'h0, seen}, 32'h0);
    wr(`MCS_OFFSET, 32'h0);
  endtask

  task automatic err_chk(input logic an, input logic dn, input logic al);
    rd(`MCS_OFFSET, r);
    chk(r & 32'h1f1f, status_exp(an, dn, al));
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == TIMEOUT) begin
      n_errors++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    oth_oe = 1'b0;
    nack_data = 1'b0;
    stretch = 1'b0;
    tx_byte = 8'h00;
    seed = 32'hd798246f;
    n_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      rd(4'(j * 4), r);
      chk(r, 32'h0);
    end
    seed = lfsr(seed);
    wr(`TAS_OFFSET, seed);
    rd(`TAS_OFFSET, r);
    chk(r, {24'h0, seed[7:0]});
    wr(`MCS_OFFSET, 32'h10);
    wr(`MCS_OFFSET, 32'h88);
    rd(`MCS_OFFSET, r);
    chk(r & 32'h1f, 32'h18);
    wr(`MCS_OFFSET, 32'h0);
    wr(`MCS_OFFSET, 32'h98);
    rd(`MCS_OFFSET, r);
    chk(r & 32'h1f, 32'h08);
    $display("Test registers done");
    seed = lfsr(seed);
    wr(`TAS_OFFSET, {24'h0, SADDR, 1'b0});
    tx(32'h7, seed[7:0]);
    chk({24'h0, addr_byte}, {24'h0, SADDR, 1'b0});
    err_chk(1'b0, 1'b0, 1'b0);
    idle_chk();
    seed = lfsr(seed);
    tx(32'h3, seed[7:0]);
    stretch = 1'b1;
    tx(32'h1, seed[15:8]);
    stretch = 1'b0;
    tx(32'h3, seed[23:16]);
    tx(32'h5, seed[31:24]);
    idle_chk();
    $display("Test send done");
    seed = lfsr(seed);
    wr(`TAS_OFFSET, {24'h0, SADDR, 1'b1});
    rx(32'hb, seed[7:0]);
    rx(32'h9, seed[15:8]);
    quiet(32'hd);
    rx(32'h5, seed[23:16]);
    idle_chk();
    rx(32'h3, seed[31:24]);
    rx(32'h3, seed[15:8]);
    xfer(32'h4, 8'h00);
    idle_chk();
    $display("Test receive done");
    foreach (refused[j]) begin
      quiet(refused[j]);
    end
    $display("Test refused done");
    wr(`TAS_OFFSET, {24'h0, SADDR ^ 7'h01, 1'b0});
    xfer(32'h7, seed[7:0]);
    err_chk(1'b1, 1'b0, 1'b0);
    idle_chk();
    nack_data = 1'b1;
    wr(`TAS_OFFSET, {24'h0, SADDR, 1'b0});
    xfer(32'h7, seed[15:8]);
    err_chk(1'b0, 1'b1, 1'b0);
    nack_data = 1'b0;
    idle_chk();
    // Another master holds SDA low against our first address bit, which is 1
    fork
      begin
        @(negedge scl_w);
        oth_oe = 1'b1;
      end
    join_none
    xfer(32'h7, 8'hff);
    oth_oe = 1'b0;
    err_chk(1'b0, 1'b0, 1'b1);
    idle_chk();
    $display("Test errors done");
    xfer(32'h11, 8'h00);
    chk({31'h0, hs_mode}, 32'h1);
    chk({24'h0, addr_byte}, {24'h0, `MASTER_CODE});
    $display("Test high speed done");
    results();
  end
endmodule
`default_nettype wire

// ===== bench/i2c_slave_model.sv
// Behavioural I2C slave: acks one address, stores written bytes, supplies read bytes
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack_data,
  input  wire logic       stretch,
  input  wire logic [7:0] tx_byte,
  output logic            sda_oe,
  output logic            scl_oe,
  output logic      [7:0] rx_byte,
  output logic      [7:0] addr_byte
);
  int         n = 0;
  int         k = 0;
  logic       act = 1'b0;
  logic       rd = 1'b0;
  logic       ack_oe = 1'b0;
  logic       rdrv = 1'b0;
  logic [2:0] rb = 3'h0;
  logic [7:0] sh = 8'h00;

  // Read bits follow tx_byte live, so a byte set while SCL is low is the one sent
  assign sda_oe = ack_oe | (rdrv & ~tx_byte[rb]);

  initial begin
    scl_oe = 1'b0;
    rx_byte = 8'h00;
    addr_byte = 8'h00;
  end

  // A start restarts the frame count, even in mid-byte
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      n = 0;
      k = 0;
    end
  end

  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (act && n < 8) begin
      sh = {sh[6:0], sda};
      n++;
    end else if (act) begin
      // Master nack on read data ends our part in the frame
      if (rd && k > 0 && sda) begin
        act = 1'b0;
      end
      n = 0;
      k++;
    end
  end

  // Released lines float to the pull-up level, never the last driven value
  always @(negedge scl) begin
    ack_oe = 1'b0;
    rdrv = 1'b0;
    if (act && n == 8 && k == 0) begin
      addr_byte = sh;
      rd = sh[0];
      act = (sh[7:1] == ADDR);
      ack_oe = act;
    end else if (act && n == 8 && !rd) begin
      rx_byte = sh;
      ack_oe = !nack_data;
    end else if (act && n < 8 && rd && k > 0) begin
      rb = 3'(7 - n);
      rdrv = 1'b1;
    end
    if (act && stretch && n == 8) begin
      scl_oe = 1'b1;
      // Longer than the master's low half bit, so its wait is really exercised
      #8000;
      scl_oe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/i2c_master_command_engine.sv
// I2C master command engine: registers, command decode and SCL/SDA bit sequencer
`include "i2c_master_command_engine_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Data-not-acknowledged flag set when a sent data byte got no acknowledge.
// - Address-not-acknowledged flag set when the sent address got no acknowledge.
// - Error flag set on address nack, data nack or lost arbitration.
// - Busy flag high while a byte moves; other flags invalid then.
// - Write with gate bit set updates only the four low command bits.
// - From idle, high-speed with run only sends master code, enters high speed.
// - Start gives START from idle, repeated START when the bus is owned.
// - Stop bit chooses STOP after data or keeping the bus for bursts.
// - Run launches the sequence selected by the other command bits.
// - Interrupt raised when a sequence completes or aborts on error.
// - From idle, start+run issue START and address, then send or receive.
// - Transmitter: run sends byte; stop alone STOPs; stop+run sends then STOPs.
// - Start+run in transmitter or receiver mode gives repeated START then transfer.
// - Receiver: run receives with ack bit response; nack with stop appends STOP.
// - Unlisted command combinations are no-operations.
// - Target address comes from bits 7..1 of the target address register.
// - Direction bit 0 selects receive when 1, send when 0.
// - Buffer is transmit byte when written, last received byte when read.
// - Written buffer byte is shifted out most significant bit first.
// - Arbitration-lost flag set when the last operation lost arbitration.
module i2c_master_command_engine
  import i2c_master_command_engine_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RESETN,
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic        I_SCL,
  output logic             O_SCL,
  output logic             O_SCL_OE,
  input  wire logic        I_SDA,
  output logic             O_SDA,
  output logic             O_SDA_OE,
  output logic             O_IRQ,
  output logic             O_HS_MODE
);

  typedef enum logic [3:0] {
    S_IDLE,
    S_START,
    S_BIT,
    S_ACK,
    S_STOP,
    S_DONE
  } seq_t;

  localparam logic [7:0] QCYC = 8'(`QUARTER_CYC - 1);

  cmd_t     cmd_q;
  logic [7:0] tas_q;
  logic [7:0] txbuf_q;
  logic [7:0] rxbuf_q;
  status_t  st_q;
  mode_t    mode_q;
  seq_t     seq_q;
  plan_t    plan_q;
  logic [7:0] shift_q;
  logic [3:0] bitcnt_q;
  logic [1:0] phase_q;
  logic [7:0] tick_q;
  logic       in_addr_q;
  logic       in_hs_q;
  logic       scl_low_q;
  logic       sda_low_q;
  logic       irq_q;
  logic       hs_q;
  logic [31:0] rdata_q;

  wire tick = (tick_q == 8'h00);
  wire wr_mcs = I_WR && (I_ADDR == `MCS_OFFSET);

  // Decodes one command against the present mode into a bus plan
  function automatic plan_t decode(input cmd_t c, input mode_t m, input logic rx_dir);
    plan_t p;
    p = '{valid: 1'b0, do_start: 1'b0, do_addr: 1'b0, do_hs: 1'b0,
          data: OP_NONE, do_stop: 1'b0, next_mode: m};
    if (!c.hs && c.start && c.run) begin
      if (!(rx_dir && c.ack && c.stop)) begin
        p.valid    = 1'b1;
        p.do_start = 1'b1;
        p.do_addr  = 1'b1;
        p.data     = rx_dir ? OP_RECV : OP_SEND;
        p.do_stop  = c.stop;
        p.next_mode = c.stop ? M_IDLE : (rx_dir ? M_RX : M_TX);
      end
    end else if (c.hs && !c.start && !c.stop && c.run && !c.ack && m == M_IDLE) begin
      p.valid = 1'b1;
      p.do_hs = 1'b1;
    end else if (!c.hs && !c.start && m == M_TX && (c.run || c.stop)) begin
      p.valid   = 1'b1;
      p.data    = c.run ? OP_SEND : OP_NONE;
      p.do_stop = c.stop;
      p.next_mode = c.stop ? M_IDLE : M_TX;
    end else if (!c.hs && !c.start && m == M_RX && (c.run || c.stop)) begin
      if (!(c.run && c.ack && c.stop)) begin
        p.valid   = 1'b1;
        p.data    = c.run ? OP_RECV : OP_NONE;
        p.do_stop = c.stop;
        p.next_mode = c.stop ? M_IDLE : M_RX;
      end
    end
    return p; // unlisted combinations stay invalid
  endfunction

  plan_t      new_plan;

  assign new_plan = decode(cmd_q, mode_q, tas_q[0]);

  // Command register; run, start and stop clear once run or stop is seen in idle, whether the command is accepted or refused
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cmd_q <= cmd_t'(`CMD_RESET);
    end else if (wr_mcs) begin
      cmd_q.run   <= I_WDATA[`MCS_RUN_BIT];
      cmd_q.start <= I_WDATA[`MCS_START_BIT];
      cmd_q.stop  <= I_WDATA[`MCS_STOP_BIT];
      cmd_q.ack   <= I_WDATA[`MCS_ACK_BIT];
      if (!I_WDATA[`MCS_GATE_BIT]) begin
        cmd_q.hs <= I_WDATA[`MCS_HS_BIT];
      end
    end else if (seq_q == S_IDLE && (cmd_q.run || cmd_q.stop)) begin
      cmd_q.run   <= 1'b0;
      cmd_q.stop  <= 1'b0;
      cmd_q.start <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tas_q   <= `TAS_RESET;
      txbuf_q <= `BUF_RESET;
    end else if (I_WR) begin
      if (I_ADDR == `TAS_OFFSET) begin
        tas_q <= I_WDATA[7:0];
      end
      if (I_ADDR == `BUF_OFFSET) begin
        txbuf_q <= I_WDATA[7:0];
      end
    end
  end

  // Quarter-bit timer; SCL held low by a slave stretches the high quarter
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tick_q <= 8'h00;
    end else if (seq_q == S_IDLE || tick) begin
      tick_q <= (phase_q == 2'd2 && !scl_low_q && !I_SCL) ? 8'h00 : QCYC;
    end else begin
      tick_q <= tick_q - 8'h01;
    end
  end

  wire stretch = (phase_q == 2'd2) && !scl_low_q && !I_SCL;
  wire tx_bit  = (seq_q == S_BIT) && !(plan_q.data == OP_RECV && !in_addr_q && !in_hs_q);
  wire arb_lost = tx_bit && !sda_low_q && !I_SDA && phase_q == 2'd2 && tick;

  // Bit sequencer, four quarters per bit: SCL low, rise, high sample, fall
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      seq_q     <= S_IDLE;
      plan_q    <= '0;
      phase_q   <= 2'd0;
      bitcnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      in_addr_q <= 1'b0;
      in_hs_q   <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      mode_q    <= M_IDLE;
      hs_q      <= 1'b0;
      rxbuf_q   <= `BUF_RESET;
      st_q      <= '0;
      irq_q     <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      case (seq_q)
        S_IDLE: begin
          if ((cmd_q.run || cmd_q.stop) && !wr_mcs) begin
            if (new_plan.valid) begin
              plan_q  <= new_plan;
              st_q    <= '{arb_lost: 1'b0, data_nack: 1'b0, addr_nack: 1'b0, error: 1'b0, busy: 1'b1};
              phase_q <= 2'd0;
              if (new_plan.do_start || new_plan.do_hs) begin
                // Master code needs a START too, or no slave frames it
                seq_q <= S_START;
              end else if (new_plan.data != OP_NONE) begin
                seq_q <= S_BIT;
                shift_q <= txbuf_q;
                bitcnt_q <= 4'h0;
              end else begin
                seq_q <= S_STOP;
              end
            end
          end
        end
        S_START: if (tick) begin
          // Release both lines, then pull SDA low while SCL high
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_low_q <= 1'b0;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b1;
            default: begin
              scl_low_q <= 1'b1;
              seq_q     <= S_BIT;
              bitcnt_q  <= 4'h0;
              if (plan_q.do_hs) begin
                in_hs_q <= 1'b1;
                shift_q <= `MASTER_CODE;
              end else begin
                in_addr_q <= 1'b1;
                shift_q   <= tas_q;
              end
            end
          endcase
        end
        S_BIT, S_ACK: if (tick && !stretch) begin
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: begin
              scl_low_q <= 1'b1;
              if (seq_q == S_ACK) begin
                sda_low_q <= (plan_q.data == OP_RECV && !in_addr_q) ? cmd_q.ack : 1'b0;
              end else begin
                sda_low_q <= tx_bit ? !shift_q[7] : 1'b0;
              end
            end
            2'd1: scl_low_q <= 1'b0;
            2'd2: begin
              if (arb_lost) begin
                st_q.arb_lost <= 1'b1;
                st_q.error    <= 1'b1;
                sda_low_q <= 1'b0;
                scl_low_q <= 1'b0;
                mode_q    <= M_IDLE;
                in_addr_q <= 1'b0;
                in_hs_q   <= 1'b0;
                seq_q     <= S_DONE;
              end else if (seq_q == S_BIT) begin
                shift_q <= {shift_q[6:0], I_SDA};
              end else if (I_SDA && in_addr_q) begin
                st_q.addr_nack <= 1'b1;
                st_q.error     <= 1'b1;
              end else if (I_SDA && !in_hs_q && plan_q.data == OP_SEND) begin
                st_q.data_nack <= 1'b1;
                st_q.error     <= 1'b1;
              end
            end
            default: begin
              scl_low_q <= 1'b1;
              if (seq_q == S_BIT) begin
                bitcnt_q <= bitcnt_q + 4'h1;
                if (bitcnt_q == 4'h7) begin
                  seq_q <= S_ACK;
                end
              end else if (in_hs_q) begin
                in_hs_q <= 1'b0;
                hs_q    <= 1'b1;
                seq_q   <= S_DONE;
              end else if (in_addr_q) begin
                in_addr_q <= 1'b0;
                if (st_q.addr_nack) begin
                  seq_q <= S_STOP;
                end else begin
                  seq_q    <= S_BIT;
                  shift_q  <= txbuf_q;
                  bitcnt_q <= 4'h0;
                end
              end else begin
                if (plan_q.data == OP_RECV) begin
                  rxbuf_q <= shift_q;
                end
                seq_q <= (plan_q.do_stop || st_q.data_nack) ? S_STOP : S_DONE;
              end
            end
          endcase
        end
        S_STOP: if (tick) begin
          // SDA low under low SCL, raise SCL, then release SDA
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: begin
              scl_low_q <= 1'b1;
              sda_low_q <= 1'b1;
            end
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b0;
            default: begin
              hs_q  <= 1'b0;
              seq_q <= S_DONE;
            end
          endcase
        end
        S_DONE: begin
          st_q.busy <= 1'b0;
          irq_q     <= 1'b1;
          seq_q     <= S_IDLE;
          if (!st_q.arb_lost) begin
            mode_q <= (st_q.addr_nack || plan_q.do_stop) ? M_IDLE : plan_q.next_mode;
          end
        end
        default: seq_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_q <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        `MCS_OFFSET: rdata_q <= {19'h0_0000, st_q.arb_lost, st_q.data_nack, st_q.addr_nack,
                                  st_q.error, st_q.busy, 3'h0, cmd_q.hs, cmd_q.ack,
                                  cmd_q.stop, cmd_q.start, cmd_q.run};
        `TAS_OFFSET: rdata_q <= {24'h00_0000, tas_q};
        `BUF_OFFSET: rdata_q <= {24'h00_0000, rxbuf_q};
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Open-drain: only ever drive low
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SCL_OE <= 1'b0;
      O_SDA_OE <= 1'b0;
    end else begin
      O_SCL_OE <= scl_low_q;
      O_SDA_OE <= sda_low_q;
    end
  end

  assign O_SCL     = 1'b0;
  assign O_SDA     = 1'b0;
  assign O_RDATA   = rdata_q;
  assign O_IRQ     = irq_q;
  assign O_HS_MODE = hs_q;

  a_busy_end_irq: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    $fell(st_q.busy) |-> irq_q)
    else $error("busy fell without interrupt");
  a_error_cause: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    st_q.error |-> (st_q.addr_nack || st_q.data_nack || st_q.arb_lost))
    else $error("error flag without cause");
  a_gate_keeps_hs: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (wr_mcs && I_WDATA[`MCS_GATE_BIT]) |=> (cmd_q.hs == $past(cmd_q.hs)))
    else $error("gated write changed high speed bit");
  a_illegal_nop: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (seq_q == S_IDLE && cmd_q.run && !wr_mcs && !new_plan.valid) |=> (seq_q == S_IDLE && mode_q == $past(mode_q)))
    else $error("illegal command started activity");
  a_start_first: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (seq_q == S_IDLE && !wr_mcs && cmd_q.run && new_plan.valid && new_plan.do_start) |=> seq_q == S_START)
    else $error("start command did not begin with START");
  a_run_consumed: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (seq_q == S_IDLE && cmd_q.run && !wr_mcs) |=> !cmd_q.run)
    else $error("run bit not consumed");
  a_addr_nack_stop: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    $rose(st_q.addr_nack) |-> ##[1:400] seq_q == S_STOP)
    else $error("address nack not followed by STOP");
  a_busy_launch: assert property (@(posedge I_MCLK) disable iff (!I_RESETN)
    (seq_q == S_IDLE && !wr_mcs && (cmd_q.run || cmd_q.stop) && new_plan.valid) |=> st_q.busy)
    else $error("busy not set on launch");

endmodule

`default_nettype wire

// ===== verilog/i2c_master_command_engine_pkg.sv
// Types shared by the I2C master command engine
package i2c_master_command_engine_pkg;

  typedef struct packed {
    logic hs;
    logic ack;
    logic stop;
    logic start;
    logic run;
  } cmd_t;

  typedef struct packed {
    logic arb_lost;
    logic data_nack;
    logic addr_nack;
    logic error;
    logic busy;
  } status_t;

  typedef enum logic [1:0] {
    M_IDLE,
    M_TX,
    M_RX
  } mode_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_SEND,
    OP_RECV
  } data_op_t;

  typedef struct packed {
    logic     valid;
    logic     do_start;
    logic     do_addr;
    logic     do_hs;
    data_op_t data;
    logic     do_stop;
    mode_t    next_mode;
  } plan_t;

endpackage

// ===== verilog/i2c_master_command_engine_regs.svh
// Register offsets, field positions, reset values and timing counts of the I2C master command engine
`ifndef I2C_MASTER_COMMAND_ENGINE_REGS_SVH
`define I2C_MASTER_COMMAND_ENGINE_REGS_SVH

`define MCS_OFFSET       4'h0
`define TAS_OFFSET       4'h4
`define BUF_OFFSET       4'h8

`define MCS_RUN_BIT      0
`define MCS_START_BIT    1
`define MCS_STOP_BIT     2
`define MCS_ACK_BIT      3
`define MCS_HS_BIT       4
`define MCS_GATE_BIT     7
`define MCS_BUSY_BIT     8
`define MCS_ERROR_BIT    9
`define MCS_ADDRNACK_BIT 10
`define MCS_DATANACK_BIT 11
`define MCS_ARBITRATION_LOST_FLAG_BIT  12

`define CMD_RESET        5'h00
`define TAS_RESET        8'h00
`define BUF_RESET        8'h00

// Quarter SCL period: 2500 ns at 25 ns clock -> 100 kHz bus
`define QUARTER_NS       2500
`define CLK_NS           25
`define QUARTER_CYC      (`QUARTER_NS / `CLK_NS)
`define MASTER_CODE      8'h0f

`endif
